// *** include/lsst_pkg.sv ***
package lsst_pkg;
    // pixel count of one scan line
    localparam int unsigned PIXELS = 2496;
    // strobe number, counted from one, of the first valid pixel
    localparam int unsigned FIRST_VALID_STROBE = 51;
    // extra integration cycles after the start pulse falls
    localparam int unsigned INTEG_EXTRA = 34;
    // least start pulse phases and period, in pixel clock periods
    localparam int unsigned START_HIGH_MIN = 6;
    localparam int unsigned START_LOW_MIN = 64;
    localparam int unsigned START_PERIOD_MIN = 70;
    // last strobe of a line, counted from one
    localparam int unsigned LAST_STROBE = FIRST_VALID_STROBE + PIXELS - 1;
    localparam int unsigned CNT_W = 13;
    localparam int unsigned INTEG_W = 24;
    localparam logic [CNT_W-1:0] CNT_RST = 13'h0000;
    localparam logic [INTEG_W-1:0] INTEG_RST = 24'h00_0000;
    typedef enum logic [1:0] {LSST_IDLE, LSST_EXPOSE, LSST_SHIFT} lsst_state_t;
endpackage : lsst_pkg

// *** hdl/lsst_core.sv ***
// Functional notes
// - one video value leaves per pixel clock cycle, and the clock stays within 200 kHz to 10 MHz.
// - integration lasts the start pulse high time plus 34 pixel clocks.
// - shifting begins on the third rising clock edge after the start pulse falls, once the fall has crossed the two-flop synchroniser.
// - a trigger strobe marks each pixel and the controller samples video just after the falling pixel clock edge.
// - each scan delivers 2496 pixel values in order along the line.
`timescale 1ns/1ns
`default_nettype none
module lsst_core (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // start pulse pin
    input wire logic line_start_pulse,
    // pixel level for the current index
    input wire logic [11:0] pixel_level,
    // readout
    output logic [lsst_pkg::CNT_W-1:0] pixel_index,
    output logic [11:0] video_out,
    output logic trig_strobe,
    output logic pixel_valid,
    output logic scan_done_pulse,
    output logic [lsst_pkg::INTEG_W-1:0] integ_cycles
);
    import lsst_pkg::*;

    logic start_meta_q;
    logic start_sync_q;
    logic start_prev_q;
    logic start_fall;
    logic start_rise;
    lsst_state_t state_q;
    logic [CNT_W-1:0] strobe_cnt_q;
    logic [INTEG_W-1:0] high_cnt_q;
    logic [INTEG_W-1:0] integ_q;
    logic [11:0] video_q;
    logic trig_q;
    logic valid_q;
    logic done_q;

    // pin crosses in through two flops before use
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            start_meta_q <= 1'b0;
            start_sync_q <= 1'b0;
            start_prev_q <= 1'b0;
        end else begin
            start_meta_q <= line_start_pulse;
            start_sync_q <= start_meta_q;
            start_prev_q <= start_sync_q;
        end
    end

    assign start_fall = start_prev_q && !start_sync_q;
    assign start_rise = !start_prev_q && start_sync_q;

    // scan sequencing; a new fall restarts the line even mid-scan
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q <= LSST_IDLE;
        end else if (start_fall) begin
            state_q <= LSST_SHIFT;
        end else begin
            unique case (state_q)
                LSST_IDLE: begin
                    if (start_rise) begin
                        state_q <= LSST_EXPOSE;
                    end
                end
                LSST_EXPOSE: begin
                    state_q <= LSST_EXPOSE;
                end
                LSST_SHIFT: begin
                    if (strobe_cnt_q == CNT_W'(LAST_STROBE)) begin
                        state_q <= LSST_IDLE;
                    end
                end
            endcase
        end
    end

    // strobe counter, one step per clock while shifting
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            strobe_cnt_q <= CNT_RST;
        end else if (start_fall) begin
            strobe_cnt_q <= CNT_W'(1);
        end else if (state_q == LSST_SHIFT && strobe_cnt_q != CNT_W'(LAST_STROBE)) begin
            strobe_cnt_q <= strobe_cnt_q + CNT_W'(1);
        end
    end

    // integration = high time + fixed extra; the high count saturates, but the sum is not clamped and can wrap
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            high_cnt_q <= INTEG_RST;
            integ_q <= INTEG_RST;
        end else begin
            if (start_rise) begin
                high_cnt_q <= INTEG_W'(1);
            end else if (start_sync_q && high_cnt_q != {INTEG_W{1'b1}}) begin
                high_cnt_q <= high_cnt_q + INTEG_W'(1);
            end
            if (start_fall) begin
                integ_q <= high_cnt_q + INTEG_W'(INTEG_EXTRA);
            end
        end
    end

    // per-pixel outputs; strobe and data registered together
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            video_q <= 12'h000;
            trig_q <= 1'b0;
            valid_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            trig_q <= (state_q == LSST_SHIFT);
            valid_q <= (state_q == LSST_SHIFT) && !start_fall &&
                       (strobe_cnt_q >= CNT_W'(FIRST_VALID_STROBE));
            video_q <= pixel_level;
            done_q <= (state_q == LSST_SHIFT) && !start_fall &&
                      (strobe_cnt_q == CNT_W'(LAST_STROBE));
        end
    end

    assign pixel_index = (strobe_cnt_q >= CNT_W'(FIRST_VALID_STROBE)) ?
                         strobe_cnt_q - CNT_W'(FIRST_VALID_STROBE) : CNT_RST;
    assign video_out = video_q;
    assign trig_strobe = trig_q;
    assign pixel_valid = valid_q;
    assign scan_done_pulse = done_q;
    assign integ_cycles = integ_q;

    // checker helpers, kept apart from the scan counter so the checks do not echo it
    logic [CNT_W-1:0] chk_age_q;
    logic [CNT_W-1:0] chk_pix_q;

    // clocks since the last synchronised fall; saturates on a stalled line
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            chk_age_q <= CNT_RST;
        end else if (start_fall) begin
            chk_age_q <= CNT_RST;
        end else if (chk_age_q != {CNT_W{1'b1}}) begin
            chk_age_q <= chk_age_q + CNT_W'(1);
        end
    end

    // valid pixels already handed out on this line
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            chk_pix_q <= CNT_RST;
        end else if (start_fall) begin
            chk_pix_q <= CNT_RST;
        end else if (pixel_valid && chk_pix_q != {CNT_W{1'b1}}) begin
            chk_pix_q <= chk_pix_q + CNT_W'(1);
        end
    end

    // shifting begins right after the synchronised fall
    AST_SHIFT_START: assert property (@(posedge mclk) disable iff (sys_rst)
        start_fall |=> state_q == LSST_SHIFT && strobe_cnt_q == CNT_W'(1))
        else $error("shift did not start after start fall");

    // integration figure is high count plus the fixed extra
    AST_INTEG: assert property (@(posedge mclk) disable iff (sys_rst)
        start_fall |=> integ_q == $past(high_cnt_q) + INTEG_W'(INTEG_EXTRA))
        else $error("integration time wrong");

    // strobe follows shifting by one clock
    AST_STROBE: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_q == LSST_SHIFT) |=> trig_strobe)
        else $error("missing trigger strobe");

    // first valid pixel rides strobe 51; the index already points one ahead
    sequence s_valid_off;
        !pixel_valid;
    endsequence
    sequence s_valid_on;
        pixel_valid && trig_strobe;
    endsequence
    AST_FIRST_VALID: assert property (@(posedge mclk) disable iff (sys_rst)
        s_valid_off ##1 s_valid_on |->
        chk_age_q == CNT_W'(FIRST_VALID_STROBE) && pixel_index == CNT_W'(1))
        else $error("first valid pixel misplaced");

    // valid is never raised without a strobe
    AST_VALID_TRIG: assert property (@(posedge mclk) disable iff (sys_rst)
        pixel_valid |-> trig_strobe)
        else $error("valid without strobe");

    // video of a valid pixel is the level fetched one clock before
    AST_VIDEO_PAIR: assert property (@(posedge mclk) disable iff (sys_rst)
        pixel_valid |-> video_out == $past(pixel_level))
        else $error("video value not paired with its pixel");

    // end of scan comes with the last pixel, after all the other valid ones of the line
    AST_DONE: assert property (@(posedge mclk) disable iff (sys_rst)
        scan_done_pulse |-> pixel_valid && $past(strobe_cnt_q) == CNT_W'(LAST_STROBE) &&
        chk_age_q == CNT_W'(LAST_STROBE) && chk_pix_q == CNT_W'(PIXELS - 1))
        else $error("end of scan misplaced");

    // end of scan is a single cycle pulse
    AST_DONE_PULSE: assert property (@(posedge mclk) disable iff (sys_rst)
        scan_done_pulse |=> !scan_done_pulse)
        else $error("end of scan longer than one cycle");

    // strobes stop once the line is out
    AST_STROBE_END: assert property (@(posedge mclk) disable iff (sys_rst)
        scan_done_pulse |=> !trig_strobe && !pixel_valid)
        else $error("strobes continue after end of scan");

    // idle after the last pixel unless a new line starts
    AST_END_IDLE: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_q == LSST_SHIFT && strobe_cnt_q == CNT_W'(LAST_STROBE) && !start_fall)
        |=> state_q == LSST_IDLE)
        else $error("scan did not end after 2496 pixels");

    // reset silences strobe, valid, done and integration on the next clock; deliberately not disabled by reset
    AST_RESET_QUIET: assert property (@(posedge mclk)
        sys_rst |=> !trig_strobe && !pixel_valid && !scan_done_pulse &&
        integ_cycles == INTEG_RST)
        else $error("outputs not cleared by reset");
endmodule : lsst_core
`default_nettype wire

// *** test/lsst_ctl_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module lsst_ctl_model (
    // pixel clock
    input wire logic mclk,
    // sensor side
    input wire logic trig_strobe,
    output logic line_start_pulse,
    output var int strobe_cnt
);
    initial line_start_pulse = 1'b0;
    initial strobe_cnt = 0;
    // strobes since the fall, this cycle included, so valid lines up with its own strobe
    always @(negedge mclk) begin
        if (line_start_pulse) begin
            strobe_cnt <= 0;
        end else begin
            strobe_cnt <= strobe_cnt + int'(trig_strobe);
        end
    end
    // high phase sets integration; caller waits out the scan, so low phase stays above 64
    task automatic pulse(input int hi);
        @(negedge mclk);
        line_start_pulse <= 1'b1;
        repeat (hi) @(negedge mclk);
        line_start_pulse <= 1'b0;
    endtask : pulse
endmodule : lsst_ctl_model
`default_nettype wire

// *** test/linear_sensor_scan_timing_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module linear_sensor_scan_timing_test;
    import lsst_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] pixel_level = 12'h000;
    logic line_start_pulse;
    logic [CNT_W-1:0] pixel_index;
    logic [11:0] video_out;
    logic trig_strobe;
    logic pixel_valid;
    logic scan_done_pulse;
    logic [INTEG_W-1:0] integ_cycles;
    int strobe_cnt;
    int err_total = 0;
    int tests_run = 0;
    logic [31:0] seed = 32'h04c3_8e4d;
    logic [11:0] salt = 12'h000;
    // even duty clock
    always #4 mclk = ~mclk;
    lsst_core dut (.mclk(mclk), .sys_rst(sys_rst), .line_start_pulse(line_start_pulse),
        .pixel_level(pixel_level), .pixel_index(pixel_index), .video_out(video_out),
        .trig_strobe(trig_strobe), .pixel_valid(pixel_valid),
        .scan_done_pulse(scan_done_pulse), .integ_cycles(integ_cycles));
    lsst_ctl_model ctl (.mclk(mclk), .trig_strobe(trig_strobe),
        .line_start_pulse(line_start_pulse), .strobe_cnt(strobe_cnt));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    // salted for each of the five looped lines; the line after the reset reuses the last salt
    function automatic logic [11:0] lvl(input int i);
        return 12'(i) * 12'h005 ^ salt;
    endfunction : lvl
    // light level follows the index the sensor asks for
    always @(negedge mclk) pixel_level <= lvl(int'(pixel_index));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    // strobe, valid, done and integration quiet after a reset release
    task automatic check_idle;
        check("idle strobe", trig_strobe, 1'b0);
        check("idle valid", pixel_valid, 1'b0);
        check("idle done", scan_done_pulse, 1'b0);
        check("idle integration", integ_cycles, INTEG_RST);
    endtask : check_idle
    task automatic final_report;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    // one line: pulse, then collect every valid sample up to the done pulse
    task automatic run_line(input int hi);
        int k;
        int n;
        k = 0;
        ctl.pulse(hi);
        for (n = 0; n < 2700 && scan_done_pulse !== 1'b1; n++) begin
            @(negedge mclk);
            #1;
            if (pixel_valid === 1'b1) begin
                if (k == 0) check("first strobe", strobe_cnt, FIRST_VALID_STROBE);
                check("video", video_out, lvl(k));
                k++;
            end
        end
        if (n >= 2700) begin
            err_total++;
            final_report();
        end
        check("pixels at done", k, PIXELS);
        check("strobe at done", strobe_cnt, LAST_STROBE);
        check("integration", integ_cycles, hi + INTEG_EXTRA);
        // strobes must stop right after the done cycle
        @(negedge mclk);
        #1;
        check("strobe after done", trig_strobe, 1'b0);
        check("valid after done", pixel_valid, 1'b0);
    endtask : run_line
    initial begin
        int hi;
        repeat (6) @(posedge mclk);
        @(negedge mclk) sys_rst <= 1'b0;
        @(negedge mclk);
        check_idle();
        // shortest high phase first, then random ones
        for (int i = 0; i < 5; i++) begin
            seed = xs(seed);
            salt = seed[27:16];
            hi = (i == 0) ? START_HIGH_MIN : START_HIGH_MIN + int'(seed[7:0]);
            run_line(hi);
        end
        // reset in mid-scan, then a clean line must follow
        ctl.pulse(START_HIGH_MIN);
        repeat (100) @(negedge mclk);
        sys_rst <= 1'b1;
        repeat (6) @(negedge mclk);
        sys_rst <= 1'b0;
        @(negedge mclk);
        #1;
        check_idle();
        run_line(START_HIGH_MIN + 1);
        final_report();
    end
endmodule : linear_sensor_scan_timing_test
`default_nettype wire
